//--- src/aops_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Each set disable bit powers down its mapped output driver; clear keeps it on.
// - Bit map: low 7 lane B5, 3 input clock; mid 4 frame, 0 B6; high 1 A6, 0 A5.
// - Input clock buffer also needs external enables; output bit clock has own control.
// - Mask bit 3 set keeps sampling clock buffer alive in whole-chip sleep.
// - Mask bit 2 set keeps reference amplifier alive in whole-chip sleep.
// - Mask bit 1 set powers bandgap down in sleep; clear keeps it on.
// - Control bit 7 chooses shared pin function: sleep when 0, sync when 1.
// - Toggling control bit 6 issues sync, only while bit 5 enables register sync.
// - Control bit 6 holds its written value and never clears itself.
// - Control bit 5 takes sync from the register instead of the shared pin.
// - Control bit 3 gives reference and clock choice to register over reference pin.
// - Reference field: 00 internal, 01 buffered external, 10 external, 11 unused.
// - Control bit 0, while bit 3 is set, picks single-ended clock and powers down differential buffer.
// - Whole-chip sleep switches off clock buffers and reference amp unless the mask spares them; bandgap only with mask bit 1.
module aops_top
  import aops_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  // Serial register port, decoded
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  // Device pins and neighbouring controls
  input wire logic SHARED_SYNC_SLEEP_PIN_I,
  input wire logic REFERENCE_BUFFER_PIN_I,
  input wire logic WHOLE_CHIP_SLEEP_REG_I,
  input wire logic INPUT_CLOCK_ENABLE_A_I,
  input wire logic INPUT_CLOCK_ENABLE_B_I,
  input wire logic OUTPUT_BIT_CLOCK_OFF_I,
  // Output driver power downs
  output logic LANE_B_FIVE_OFF_O,
  output logic LANE_B_SIX_OFF_O,
  output logic LANE_A_FIVE_OFF_O,
  output logic LANE_A_SIX_OFF_O,
  output logic FRAME_CLOCK_OFF_O,
  output logic INPUT_BIT_CLOCK_OFF_O,
  output logic OUTPUT_BIT_CLOCK_OFF_O,
  // Analog power controls
  output logic WHOLE_CHIP_SLEEP_O,
  output logic CLOCK_BUFFER_OFF_O,
  output logic DIFF_CLOCK_BUFFER_OFF_O,
  output logic REFERENCE_AMP_OFF_O,
  output logic BANDGAP_OFF_O,
  // Reference and clock selection
  output logic REF_FROM_REGISTER_O,
  output logic [1:0] REFERENCE_SOURCE_O,
  output logic SINGLE_ENDED_CLOCK_SELECT_O,
  // Sync command pulse
  output logic SYNC_PULSE_O
);

  logic [7:0] ob_low;
  logic [7:0] ob_mid;
  logic [7:0] ob_high;
  logic [7:0] mask;
  logic [7:0] ctrl;
  logic [7:0] next_rdata;
  logic reg_sync_prev;
  logic pin_prev;
  logic sleep_now;
  logic reg_sync_edge;
  logic pin_sync_edge;

  function automatic logic [7:0] pick_reg(input logic [7:0] a);
    case (a)
      AOPS_OFS_OB_LOW: pick_reg = ob_low;
      AOPS_OFS_OB_MID: pick_reg = ob_mid;
      AOPS_OFS_OB_HIGH: pick_reg = ob_high;
      AOPS_OFS_MASK: pick_reg = mask;
      AOPS_OFS_CTRL: pick_reg = ctrl;
      default: pick_reg = 8'h00;
    endcase
  endfunction : pick_reg

  // Register storage, all zero at reset
  aops_reg8 #(.ADDR(AOPS_OFS_OB_LOW)) u_ob_low (
    .clk_i(CLK_SYS_I), .srst_i(SRST_I), .wr_i(REG_WR_I), .addr_i(REG_ADDR_I),
    .wdata_i(REG_WDATA_I), .q_o(ob_low)
  );
  aops_reg8 #(.ADDR(AOPS_OFS_OB_MID)) u_ob_mid (
    .clk_i(CLK_SYS_I), .srst_i(SRST_I), .wr_i(REG_WR_I), .addr_i(REG_ADDR_I),
    .wdata_i(REG_WDATA_I), .q_o(ob_mid)
  );
  aops_reg8 #(.ADDR(AOPS_OFS_OB_HIGH)) u_ob_high (
    .clk_i(CLK_SYS_I), .srst_i(SRST_I), .wr_i(REG_WR_I), .addr_i(REG_ADDR_I),
    .wdata_i(REG_WDATA_I), .q_o(ob_high)
  );
  aops_reg8 #(.ADDR(AOPS_OFS_MASK)) u_mask (
    .clk_i(CLK_SYS_I), .srst_i(SRST_I), .wr_i(REG_WR_I), .addr_i(REG_ADDR_I),
    .wdata_i(REG_WDATA_I), .q_o(mask)
  );
  // Bit 6 stays as written; no self clear
  aops_reg8 #(.ADDR(AOPS_OFS_CTRL)) u_ctrl (
    .clk_i(CLK_SYS_I), .srst_i(SRST_I), .wr_i(REG_WR_I), .addr_i(REG_ADDR_I),
    .wdata_i(REG_WDATA_I), .q_o(ctrl)
  );

  // Readback of stored bytes; unmapped reads as zero
  always_comb begin
    next_rdata = pick_reg(REG_ADDR_I);
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      REG_RDATA_O <= AOPS_RESET_VAL;
    end else begin
      REG_RDATA_O <= next_rdata;
    end
  end

  // Shared pin sleeps only when configured as sleep
  assign sleep_now = WHOLE_CHIP_SLEEP_REG_I
                     || (SHARED_SYNC_SLEEP_PIN_I && !ctrl[AOPS_CTL_PIN_IS_SYNC]);

  // Register sync on any toggle of bit 6, gated by enable
  assign reg_sync_edge = (ctrl[AOPS_CTL_REG_SYNC] != reg_sync_prev)
                         && ctrl[AOPS_CTL_REG_SYNC_EN];
  // Pin sync on rising level while bit 7 sets the pin to sync, unless register owns sync
  assign pin_sync_edge = SHARED_SYNC_SLEEP_PIN_I && !pin_prev
                         && ctrl[AOPS_CTL_PIN_IS_SYNC]
                         && !ctrl[AOPS_CTL_REG_SYNC_EN];

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      reg_sync_prev <= 1'b0;
      pin_prev <= 1'b0;
      SYNC_PULSE_O <= 1'b0;
    end else begin
      reg_sync_prev <= ctrl[AOPS_CTL_REG_SYNC];
      pin_prev <= SHARED_SYNC_SLEEP_PIN_I;
      SYNC_PULSE_O <= reg_sync_edge || pin_sync_edge;
    end
  end

  // Output driver power downs
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      LANE_B_FIVE_OFF_O <= 1'b0;
      LANE_B_SIX_OFF_O <= 1'b0;
      LANE_A_FIVE_OFF_O <= 1'b0;
      LANE_A_SIX_OFF_O <= 1'b0;
      FRAME_CLOCK_OFF_O <= 1'b0;
      INPUT_BIT_CLOCK_OFF_O <= 1'b1;
      OUTPUT_BIT_CLOCK_OFF_O <= 1'b0;
    end else begin
      LANE_B_FIVE_OFF_O <= ob_low[AOPS_LOW_LANE_B_FIVE];
      LANE_B_SIX_OFF_O <= ob_mid[AOPS_MID_LANE_B_SIX];
      LANE_A_FIVE_OFF_O <= ob_high[AOPS_HIGH_LANE_A_FIVE];
      LANE_A_SIX_OFF_O <= ob_high[AOPS_HIGH_LANE_A_SIX];
      FRAME_CLOCK_OFF_O <= ob_mid[AOPS_MID_FRAME_CLOCK];
      // Input clock buffer needs both outside enables too
      INPUT_BIT_CLOCK_OFF_O <= ob_low[AOPS_LOW_INPUT_BIT_CLOCK]
                               || !INPUT_CLOCK_ENABLE_A_I
                               || !INPUT_CLOCK_ENABLE_B_I;
      // Not reachable from the disable bytes by design
      OUTPUT_BIT_CLOCK_OFF_O <= OUTPUT_BIT_CLOCK_OFF_I;
    end
  end

  // Analog power and reference selection
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      WHOLE_CHIP_SLEEP_O <= 1'b0;
      CLOCK_BUFFER_OFF_O <= 1'b0;
      DIFF_CLOCK_BUFFER_OFF_O <= 1'b0;
      REFERENCE_AMP_OFF_O <= 1'b0;
      BANDGAP_OFF_O <= 1'b0;
      REF_FROM_REGISTER_O <= 1'b0;
      REFERENCE_SOURCE_O <= AOPS_REF_INTERNAL;
      SINGLE_ENDED_CLOCK_SELECT_O <= 1'b0;
    end else begin
      WHOLE_CHIP_SLEEP_O <= sleep_now;
      CLOCK_BUFFER_OFF_O <= sleep_now && !mask[AOPS_MASK_KEEP_CLK];
      REFERENCE_AMP_OFF_O <= sleep_now && !mask[AOPS_MASK_KEEP_REFAMP];
      BANDGAP_OFF_O <= sleep_now && mask[AOPS_MASK_BANDGAP_OFF];
      REF_FROM_REGISTER_O <= ctrl[AOPS_CTL_REF_OWNER];
      if (ctrl[AOPS_CTL_REF_OWNER]) begin
        REFERENCE_SOURCE_O <= ctrl[AOPS_CTL_REF_SEL_HI:AOPS_CTL_REF_SEL_LO];
        SINGLE_ENDED_CLOCK_SELECT_O <= ctrl[AOPS_CTL_SE_CLK];
      end else begin
        // Pin only picks internal versus buffered external
        REFERENCE_SOURCE_O <= REFERENCE_BUFFER_PIN_I ? AOPS_REF_EXT_BUFFERED
                                                     : AOPS_REF_INTERNAL;
        SINGLE_ENDED_CLOCK_SELECT_O <= 1'b0;
      end
      // Single-ended clock parks the differential buffer
      DIFF_CLOCK_BUFFER_OFF_O <= (ctrl[AOPS_CTL_REF_OWNER] && ctrl[AOPS_CTL_SE_CLK])
                                 || (sleep_now && !mask[AOPS_MASK_KEEP_CLK]);
    end
  end

endmodule : aops_top

//--- inc/aops_pkg.sv
package aops_pkg;
  // Register offsets on the serial register port
  localparam logic [7:0] AOPS_OFS_OB_LOW = 8'h0a;
  localparam logic [7:0] AOPS_OFS_OB_MID = 8'h0b;
  localparam logic [7:0] AOPS_OFS_OB_HIGH = 8'h0c;
  localparam logic [7:0] AOPS_OFS_MASK = 8'h0d;
  localparam logic [7:0] AOPS_OFS_CTRL = 8'h0e;
  localparam logic [7:0] AOPS_RESET_VAL = 8'h00;
  // Output buffer bit positions
  localparam int AOPS_LOW_LANE_B_FIVE = 7;
  localparam int AOPS_LOW_INPUT_BIT_CLOCK = 3;
  localparam int AOPS_MID_FRAME_CLOCK = 4;
  localparam int AOPS_MID_LANE_B_SIX = 0;
  localparam int AOPS_HIGH_LANE_A_SIX = 1;
  localparam int AOPS_HIGH_LANE_A_FIVE = 0;
  // Mask bit positions
  localparam int AOPS_MASK_KEEP_CLK = 3;
  localparam int AOPS_MASK_KEEP_REFAMP = 2;
  localparam int AOPS_MASK_BANDGAP_OFF = 1;
  // Control bit positions
  localparam int AOPS_CTL_PIN_IS_SYNC = 7;
  localparam int AOPS_CTL_REG_SYNC = 6;
  localparam int AOPS_CTL_REG_SYNC_EN = 5;
  localparam int AOPS_CTL_REF_OWNER = 3;
  localparam int AOPS_CTL_REF_SEL_HI = 2;
  localparam int AOPS_CTL_REF_SEL_LO = 1;
  localparam int AOPS_CTL_SE_CLK = 0;
  // Reference source encodings
  typedef enum logic [1:0] {
    AOPS_REF_INTERNAL = 2'h0,
    AOPS_REF_EXT_BUFFERED = 2'h1,
    AOPS_REF_EXTERNAL = 2'h2,
    AOPS_REF_UNUSED = 2'h3
  } aops_ref_t;
endpackage : aops_pkg

//--- src/aops_reg8.sv
`timescale 1ns/1ps
// One byte-wide register with write strobe and address match
module aops_reg8 #(
  parameter logic [7:0] ADDR = 8'h00
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] q_o
);
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      q_o <= 8'h00;
    end else if (wr_i && addr_i == ADDR) begin
      q_o <= wdata_i;
    end
  end
endmodule : aops_reg8

//--- bench/aops_host.sv
`timescale 1ns/1ps
module aops_host (
  // Clock
  input wire logic clk_i,
  // Register port toward the device
  output logic wr_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  input wire logic [7:0] rdata_i
);
  initial begin
    wr_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // Data is scrambled once the strobe drops, so stale bytes never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= 1'b1;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    @(posedge clk_i);
    #1 d = rdata_i;
  endtask : rd
  // All three lane bytes are written one after another, low first, after any mode change
  task automatic set_lanes(input logic [23:0] v);
    wr(8'h0a, v[23:16]);
    wr(8'h0b, v[15:8]);
    wr(8'h0c, v[7:0]);
  endtask : set_lanes
endmodule : aops_host

//--- bench/aops_top_chk.sv
`timescale 1ns/1ps
module aops_top_chk (
  // Clock, reset, register port
  input wire logic CLK_SYS_I,
  input wire logic SRST_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic [7:0] REG_RDATA_O,
  // Power and selection
  input wire logic WHOLE_CHIP_SLEEP_REG_I,
  input wire logic LANE_B_FIVE_OFF_O,
  input wire logic WHOLE_CHIP_SLEEP_O,
  input wire logic CLOCK_BUFFER_OFF_O,
  input wire logic REFERENCE_AMP_OFF_O,
  input wire logic BANDGAP_OFF_O,
  input wire logic DIFF_CLOCK_BUFFER_OFF_O,
  input wire logic REF_FROM_REGISTER_O,
  input wire logic SINGLE_ENDED_CLOCK_SELECT_O,
  input wire logic SYNC_PULSE_O
);
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);
  a_low_lane_map: assert property (REG_WR_I && REG_ADDR_I == 8'h0a |-> ##2
    LANE_B_FIVE_OFF_O == $past(REG_WDATA_I[7], 2)) else $error("lane map wrong");
  a_sleep_follow: assert property (WHOLE_CHIP_SLEEP_REG_I |=> WHOLE_CHIP_SLEEP_O)
    else $error("sleep not entered");
  a_clk_spare: assert property (CLOCK_BUFFER_OFF_O |-> WHOLE_CHIP_SLEEP_O)
    else $error("clock buffer off while awake");
  a_ref_spare: assert property (REFERENCE_AMP_OFF_O |-> WHOLE_CHIP_SLEEP_O)
    else $error("reference amp off while awake");
  a_bandgap_sleep: assert property (BANDGAP_OFF_O |-> WHOLE_CHIP_SLEEP_O)
    else $error("bandgap off while awake");
  a_sync_single: assert property (SYNC_PULSE_O |=> !SYNC_PULSE_O)
    else $error("sync pulse too long");
  a_se_owner: assert property (SINGLE_ENDED_CLOCK_SELECT_O |->
    REF_FROM_REGISTER_O && DIFF_CLOCK_BUFFER_OFF_O) else $error("single ended select bad");
  a_read_back: assert property (REG_WR_I && REG_ADDR_I inside {[8'h0a:8'h0e]} ##1
    !REG_WR_I && $stable(REG_ADDR_I) |=> REG_RDATA_O == $past(REG_WDATA_I, 2))
    else $error("readback wrong");
  cover property (SYNC_PULSE_O);
  cover property (BANDGAP_OFF_O);
  cover property (SINGLE_ENDED_CLOCK_SELECT_O);
endmodule : aops_top_chk
bind aops_top aops_top_chk i_chk (.*);

//--- bench/aops_top_tb.sv
`timescale 1ns/1ps
module aops_top_tb;
  logic clk = 1'b0, srst = 1'b1, pin = 1'b0, reference_buffer_pin = 1'b0, slp_in = 1'b0;
  logic ena = 1'b1, enb = 1'b1, obi = 1'b0;
  logic wr, lb5, lb6, la5, la6, fck, ick, obo, slp, cbo, dcb, rao, bgo, rfr, se, sp;
  logic [7:0] addr, wdata, rdata;
  logic [1:0] rsrc;
  int error_cnt = 0, total_checks = 0, pulses = 0;
  always #20 clk = ~clk;
  always @(posedge clk) if (sp === 1'b1) pulses <= pulses + 1;
  aops_host i_host (.clk_i(clk), .wr_o(wr), .addr_o(addr), .wdata_o(wdata), .rdata_i(rdata));
  aops_top i_dut (.CLK_SYS_I(clk), .SRST_I(srst), .REG_WR_I(wr), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .SHARED_SYNC_SLEEP_PIN_I(pin),
    .REFERENCE_BUFFER_PIN_I(reference_buffer_pin), .WHOLE_CHIP_SLEEP_REG_I(slp_in),
    .INPUT_CLOCK_ENABLE_A_I(ena), .INPUT_CLOCK_ENABLE_B_I(enb), .OUTPUT_BIT_CLOCK_OFF_I(obi),
    .LANE_B_FIVE_OFF_O(lb5), .LANE_B_SIX_OFF_O(lb6), .LANE_A_FIVE_OFF_O(la5),
    .LANE_A_SIX_OFF_O(la6), .FRAME_CLOCK_OFF_O(fck), .INPUT_BIT_CLOCK_OFF_O(ick),
    .OUTPUT_BIT_CLOCK_OFF_O(obo), .WHOLE_CHIP_SLEEP_O(slp), .CLOCK_BUFFER_OFF_O(cbo),
    .DIFF_CLOCK_BUFFER_OFF_O(dcb), .REFERENCE_AMP_OFF_O(rao), .BANDGAP_OFF_O(bgo),
    .REF_FROM_REGISTER_O(rfr), .REFERENCE_SOURCE_O(rsrc),
    .SINGLE_ENDED_CLOCK_SELECT_O(se), .SYNC_PULSE_O(sp));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Wait of n edges: outputs trail a register write by two edges
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle
  task automatic summarize();
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    summarize();
  end
  initial begin
    logic [7:0] d;
    int p0;
    logic [23:0] modes [3] = '{24'h7f_ee_fc, 24'hff_ee_fd, 24'hff_ef_fd};
    logic [7:0] mv [4] = '{8'h00, 8'h08, 8'h06, 8'h0e};
    logic [2:0] me [4] = '{3'b110, 3'b010, 3'b101, 3'b001};
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    i_host.wr(8'h0f, 8'hff);
    for (int a = 9; a <= 15; a++) begin
      i_host.rd(a[7:0], d);
      chk(d, 8'h00);
    end
    foreach (modes[m]) begin
      i_host.set_lanes(modes[m]);
      settle(2);
      chk({lb5, ick, fck, lb6, la6, la5}, {modes[m][23], modes[m][19], modes[m][12],
        modes[m][8], modes[m][1:0]});
      i_host.rd(8'h0c, d);
      chk(d, modes[m][7:0]);
    end
    i_host.set_lanes(24'h0);
    ena <= 1'b0;
    obi <= 1'b1;
    settle(2);
    chk({ick, obo, lb5}, 3'b110);
    ena <= 1'b1;
    enb <= 1'b0;
    settle(2);
    chk({7'h00, ick}, 8'h01);
    enb <= 1'b1;
    settle(2);
    chk({7'h00, ick}, 8'h00);
    slp_in <= 1'b1;
    foreach (mv[k]) begin
      i_host.wr(8'h0d, mv[k]);
      settle(2);
      chk({cbo, rao, bgo}, me[k]);
    end
    slp_in <= 1'b0;
    pin <= 1'b1;
    settle(3);
    chk({slp, cbo, rao, bgo}, 4'b1001);
    pin <= 1'b0;
    i_host.wr(8'h0e, 8'h80);
    p0 = pulses;
    pin <= 1'b1;
    settle(4);
    chk({slp, 7'(pulses - p0)}, 8'h01);
    pin <= 1'b0;
    p0 = pulses;
    i_host.wr(8'h0e, 8'h20);
    i_host.wr(8'h0e, 8'h60);
    settle(4);
    i_host.rd(8'h0e, d);
    chk(d, 8'h60);
    i_host.wr(8'h0e, 8'h20);
    i_host.wr(8'h0e, 8'h00);
    i_host.wr(8'h0e, 8'h40);
    settle(4);
    chk(8'(pulses - p0), 8'h02);
    for (int k = 0; k < 4; k++) begin
      i_host.wr(8'h0e, {4'h1, k[1:0], 1'b0} << 0 | 8'h08);
      settle(2);
      chk({rfr, rsrc, se}, {1'b1, k[1:0], 1'b0});
    end
    i_host.wr(8'h0e, 8'h09);
    settle(2);
    chk({rfr, rsrc, se, dcb}, 5'b10011);
    i_host.wr(8'h0e, 8'h01);
    reference_buffer_pin <= 1'b1;
    settle(2);
    chk({rfr, rsrc, se, dcb}, 5'b00100);
    summarize();
  end
endmodule : aops_top_tb
